/* common/tmr_pkg.sv */
// Contract
// - Reset clears the control register to zero: stopped, clear mode, undivided clock.
// - Enable bit 7 low holds counter at zero; high counts selected pulses.
// - Mode bit 6: 0 clear-and-start after match, 1 free-running.
// - Bit 3 is a read-only overflow flag; writes to bit 3 are ignored, but it clears once enable bit 7 is low.
// - Clock select bits 1:0 pick divide by 1, 4, 32 or 1024.
// - Clear mode: on match counter returns to zero, keeps counting, match irq.
// - Free mode: on match raise match irq, counter keeps incrementing.
// - Free mode: counter wrap raises a separate overflow irq.
// - Combined irq is the OR of match irq and overflow irq.
// - Free mode with compare all ones never raises match irq.
// - First match may lag up to one count pulse after enabling.
// - Free mode: counter returns to zero right after overflow.
// - Reset loads compare register with zero.
// - Counter is neither readable nor writable; only compare and control.
//
`default_nettype none
// ----------------------------------------------------------------
// constants and types of the 16-bit timer
// ----------------------------------------------------------------
package tmr_pkg;
    // register addresses
    localparam logic [15:0] CTL_ADDR = 16'hff5b;
    localparam logic [15:0] CMP_ADDR = 16'hff5c;
    // reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] RDATA_RESET = 16'h0000;
    // control field positions
    localparam int EN_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int OVF_BIT = 3;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;
    // clock select codes
    localparam logic [1:0] SEL_DIV1 = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam logic [1:0] SEL_DIV32 = 2'h2;
    localparam logic [1:0] SEL_DIV1024 = 2'h3;
    // prescaler terminal masks
    localparam logic [9:0] DIV_RESET = 10'h000;
    localparam logic [9:0] MASK4 = 10'h003;
    localparam logic [9:0] MASK32 = 10'h01f;
    localparam logic [9:0] MASK1024 = 10'h3ff;

    typedef enum logic {
        TMR_CLEAR_START,
        TMR_FREE_RUN
    } tmr_mode_t;

    typedef struct packed {
        logic en;
        tmr_mode_t mode;
        logic ovf;
        logic [1:0] sel;
    } tmr_ctl_t;
endpackage
`default_nettype wire

/* verilog/tmr_prescale.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// count clock prescaler
// ----------------------------------------------------------------
module tmr_prescale (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [1:0] sel,
    output logic tick
);
    logic [9:0] div_reg;
    logic [9:0] div_next;
    logic end4;
    logic end32;
    logic end1024;

    // divider runs free, so a start is not aligned to the pulse
    assign div_next = div_reg + 10'h001;
    assign end4 = (div_reg & tmr_pkg::MASK4) == tmr_pkg::MASK4;
    assign end32 = (div_reg & tmr_pkg::MASK32) == tmr_pkg::MASK32;
    assign end1024 = div_reg == tmr_pkg::MASK1024;

    // divider register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            div_reg <= tmr_pkg::DIV_RESET;
        end else begin
            div_reg <= div_next;
        end
    end

    // count pulse selection
    always_comb begin
        case (sel)
            tmr_pkg::SEL_DIV1: tick = 1'b1;
            tmr_pkg::SEL_DIV4: tick = end4;
            tmr_pkg::SEL_DIV32: tick = end32;
            tmr_pkg::SEL_DIV1024: tick = end1024;
            default: tick = 1'b0;
        endcase
    end

    chk_undivided_tick: assert property (
        @(posedge clk_sys) disable iff (srst)
        (sel == tmr_pkg::SEL_DIV1) |-> tick)
        else $error("undivided select gives no pulse");
    chk_div4_gap: assert property (
        @(posedge clk_sys) disable iff (srst)
        (tick && sel == tmr_pkg::SEL_DIV4) |-> (div_reg[1:0] == 2'h3))
        else $error("divide by four pulse off phase");
endmodule
`default_nettype wire

/* verilog/tmr_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// 16-bit interval and free-running timer
// ----------------------------------------------------------------
module tmr_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [15:0] mem_addr,
    input wire logic mem_we,
    input wire logic mem_bit_we,
    input wire logic [2:0] mem_bit_sel,
    input wire logic mem_bit_val,
    input wire logic mem_rd,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic match_irq,
    output logic overflow_irq,
    output logic combined_irq
);
    tmr_pkg::tmr_ctl_t ctl_reg;
    tmr_pkg::tmr_ctl_t ctl_next;
    logic [15:0] cmp_reg;
    logic [15:0] cmp_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic match_irq_reg;
    logic overflow_irq_reg;
    logic combined_irq_reg;
    logic tick;
    logic hit_ctl;
    logic hit_cmp;
    logic ctl_wr;
    logic cmp_wr;
    logic [7:0] ctl_rbyte;
    logic [7:0] bit_mask;
    logic [7:0] ctl_bitmerge;
    logic [7:0] ctl_wbyte;
    logic free_mode;
    logic step;
    logic at_cmp;
    logic at_max;
    logic match_ev;
    logic wrap_ev;
    logic ovf_irq_ev;
    logic [15:0] gap_reg;
    logic seen_reg;

    // ------------------------------------------------------------
    // count clock
    // ------------------------------------------------------------
    // selection is taken live; software keeps it still while running
    tmr_prescale u_prescale (
        .clk_sys(clk_sys),
        .srst(srst),
        .sel(ctl_reg.sel),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    // address decode and write strobes
    assign hit_ctl = mem_addr == tmr_pkg::CTL_ADDR;
    assign hit_cmp = mem_addr == tmr_pkg::CMP_ADDR;
    assign ctl_wr = hit_ctl && (mem_we || mem_bit_we);
    assign cmp_wr = hit_cmp && mem_we;

    // control image; unused bits read as zero
    assign ctl_rbyte = {ctl_reg.en,
                        ctl_reg.mode == tmr_pkg::TMR_FREE_RUN,
                        2'b00,
                        ctl_reg.ovf,
                        1'b0,
                        ctl_reg.sel};

    // single bit writes merge into the current image
    assign bit_mask = 8'h01 << mem_bit_sel;
    assign ctl_bitmerge = mem_bit_val ? (ctl_rbyte | bit_mask)
                                      : (ctl_rbyte & ~bit_mask);
    assign ctl_wbyte = mem_bit_we ? ctl_bitmerge : mem_wdata[7:0];

    // read mux; the counter itself is never visible
    always_comb begin
        rdata_next = rdata_reg;
        if (mem_rd) begin
            if (hit_ctl) begin
                rdata_next = {8'h00, ctl_rbyte};
            end else if (hit_cmp) begin
                rdata_next = cmp_reg;
            end else begin
                rdata_next = tmr_pkg::RDATA_RESET;
            end
        end
    end

    // ------------------------------------------------------------
    // count and compare
    // ------------------------------------------------------------
    // event terms
    assign free_mode = ctl_reg.mode == tmr_pkg::TMR_FREE_RUN;
    assign step = ctl_reg.en && tick;
    assign at_cmp = cnt_reg == cmp_reg;
    assign at_max = cnt_reg == tmr_pkg::CNT_MAX;
    assign wrap_ev = step && at_max && !(!free_mode && at_cmp);
    assign ovf_irq_ev = wrap_ev && free_mode;

    // match event per mode
    always_comb begin
        case (ctl_reg.mode)
            tmr_pkg::TMR_CLEAR_START: match_ev = step && at_cmp;
            tmr_pkg::TMR_FREE_RUN: begin
                // all-ones compare never matches
                match_ev = step && at_cmp &&
                           (cmp_reg != tmr_pkg::CNT_MAX);
            end
            default: match_ev = 1'b0;
        endcase
    end

    // counter next value
    always_comb begin
        if (!ctl_reg.en) begin
            cnt_next = tmr_pkg::CNT_RESET;
        end else if (!tick) begin
            cnt_next = cnt_reg;
        end else if (!free_mode && at_cmp) begin
            cnt_next = tmr_pkg::CNT_RESET;
        end else if (at_max) begin
            cnt_next = tmr_pkg::CNT_RESET;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    // control next value; overflow set beats the disable clear
    always_comb begin
        ctl_next = ctl_reg;
        if (ctl_wr) begin
            ctl_next.en = ctl_wbyte[tmr_pkg::EN_BIT];
            ctl_next.mode = ctl_wbyte[tmr_pkg::MODE_BIT] ?
                            tmr_pkg::TMR_FREE_RUN :
                            tmr_pkg::TMR_CLEAR_START;
            ctl_next.sel = ctl_wbyte[tmr_pkg::SEL_HI:tmr_pkg::SEL_LO];
        end
        if (wrap_ev) begin
            ctl_next.ovf = 1'b1;
        end else if (!ctl_reg.en) begin
            ctl_next.ovf = 1'b0;
        end
    end

    // compare next value; a live rewrite may match at once
    assign cmp_next = cmp_wr ? mem_wdata : cmp_reg;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // control and compare
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_reg.en <= tmr_pkg::CTL_RESET[tmr_pkg::EN_BIT];
            ctl_reg.mode <= tmr_pkg::tmr_mode_t'(
                tmr_pkg::CTL_RESET[tmr_pkg::MODE_BIT]);
            ctl_reg.ovf <= tmr_pkg::CTL_RESET[tmr_pkg::OVF_BIT];
            ctl_reg.sel <= tmr_pkg::CTL_RESET[tmr_pkg::SEL_HI:tmr_pkg::SEL_LO];
            cmp_reg <= tmr_pkg::CMP_RESET;
        end else begin
            ctl_reg <= ctl_next;
            cmp_reg <= cmp_next;
        end
    end

    // counter and read data
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_reg <= tmr_pkg::CNT_RESET;
            rdata_reg <= tmr_pkg::RDATA_RESET;
        end else begin
            cnt_reg <= cnt_next;
            rdata_reg <= rdata_next;
        end
    end

    // interrupt request pulses
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            match_irq_reg <= 1'b0;
            overflow_irq_reg <= 1'b0;
            combined_irq_reg <= 1'b0;
        end else begin
            match_irq_reg <= match_ev;
            overflow_irq_reg <= ovf_irq_ev;
            combined_irq_reg <= match_ev | ovf_irq_ev;
        end
    end

    // outputs
    assign mem_rdata = rdata_reg;
    assign match_irq = match_irq_reg;
    assign overflow_irq = overflow_irq_reg;
    assign combined_irq = combined_irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // pulses between clear-mode matches, for the period check
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gap_reg <= tmr_pkg::CNT_RESET;
            seen_reg <= 1'b0;
        end else if (!ctl_reg.en || free_mode || cmp_wr || ctl_wr) begin
            gap_reg <= tmr_pkg::CNT_RESET;
            seen_reg <= 1'b0;
        end else if (match_ev) begin
            gap_reg <= tmr_pkg::CNT_RESET;
            seen_reg <= 1'b1;
        end else if (step) begin
            gap_reg <= gap_reg + 16'h0001;
        end
    end

    sequence s_clear_hit;
        ctl_reg.en && !free_mode && tick && at_cmp;
    endsequence

    sequence s_free_hit;
        ctl_reg.en && free_mode && tick && at_cmp &&
        (cmp_reg != tmr_pkg::CNT_MAX) && !at_max;
    endsequence

    sequence s_free_wrap;
        ctl_reg.en && free_mode && tick && at_max;
    endsequence

    sequence s_plain_step;
        ctl_reg.en && tick && !at_max && !(!free_mode && at_cmp);
    endsequence

    chk_ctl_reset: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        srst |=> (ctl_rbyte == tmr_pkg::CTL_RESET))
        else $error("control not cleared by reset");
    chk_cmp_reset: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        srst |=> (cmp_reg == tmr_pkg::CMP_RESET))
        else $error("compare not cleared by reset");
    chk_stop_zero: assert property (
        @(posedge clk_sys) disable iff (srst)
        (!ctl_reg.en) |=> (cnt_reg == tmr_pkg::CNT_RESET) && !match_irq)
        else $error("stopped counter not held at zero");
    chk_count_step: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_plain_step |=> (cnt_reg == $past(cnt_reg) + 16'h0001))
        else $error("counter missed a count pulse");
    chk_clear_restart: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_clear_hit |=> (cnt_reg == tmr_pkg::CNT_RESET) && match_irq)
        else $error("clear mode match did not restart");
    chk_free_pass: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_free_hit |=> match_irq && (cnt_reg == $past(cnt_reg) + 16'h0001))
        else $error("free mode match disturbed counter");
    chk_wrap_ovf: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_free_wrap |=> overflow_irq && ctl_reg.ovf &&
                        (cnt_reg == tmr_pkg::CNT_RESET))
        else $error("free mode wrap not reported");
    chk_no_match_max: assert property (
        @(posedge clk_sys) disable iff (srst)
        (free_mode && cmp_reg == tmr_pkg::CNT_MAX) |=> !match_irq)
        else $error("match raised with all-ones compare");
    chk_combined_or: assert property (
        @(posedge clk_sys) disable iff (srst)
        combined_irq == (match_irq || overflow_irq))
        else $error("combined request is not the OR");
    chk_ovf_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        (ctl_reg.en && !wrap_ev) |=> (ctl_reg.ovf == $past(ctl_reg.ovf)))
        else $error("overflow flag changed without a wrap");
    chk_ovf_clear: assert property (
        @(posedge clk_sys) disable iff (srst)
        (!ctl_reg.en) ##1 (!ctl_reg.en) |-> !ctl_reg.ovf)
        else $error("overflow flag survives disable");
    chk_match_period: assert property (
        @(posedge clk_sys) disable iff (srst)
        (match_ev && seen_reg && !free_mode) |-> (gap_reg == cmp_reg))
        else $error("clear mode period is not compare plus one");
    chk_clear_no_ovf: assert property (
        @(posedge clk_sys) disable iff (srst)
        (!free_mode) |=> !overflow_irq)
        else $error("overflow request raised in clear mode");

    // start error stays within one count pulse of the divider
    chk_start_lag: assert property (
        @(posedge clk_sys) disable iff (srst)
        ($rose(ctl_reg.en) && ctl_reg.sel == tmr_pkg::SEL_DIV32) |->
        ##[0:31] step)
        else $error("first count pulse later than one ratio");

    // register side: unmapped reads, read hold and compare loads
    chk_unmapped_zero: assert property (
        @(posedge clk_sys) disable iff (srst)
        (mem_rd && !hit_ctl && !hit_cmp) |=>
        (mem_rdata == tmr_pkg::RDATA_RESET))
        else $error("unmapped read gives nonzero data");
    chk_rdata_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        (!mem_rd) |=> (mem_rdata == $past(mem_rdata)))
        else $error("read data changed without a read");
    chk_cmp_load: assert property (
        @(posedge clk_sys) disable iff (srst)
        cmp_wr |=> (cmp_reg == $past(mem_wdata)))
        else $error("compare write did not land");
endmodule
`default_nettype wire

/* dv/tb_tmr_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench of the 16-bit timer
// ----------------------------------------------------------------
module tb_tmr_top;
    logic clk_sys;
    logic srst;
    logic [15:0] mem_addr;
    logic mem_we;
    logic mem_bit_we;
    logic [2:0] mem_bit_sel;
    logic mem_bit_val;
    logic mem_rd;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic match_irq;
    logic overflow_irq;
    logic combined_irq;
    int failures;
    int checks;
    int cyc;
    int seed;
    int mq[$];
    int oq[$];
    logic [15:0] v;

    tmr_top dut (
        .clk_sys(clk_sys),
        .srst(srst),
        .mem_addr(mem_addr),
        .mem_we(mem_we),
        .mem_bit_we(mem_bit_we),
        .mem_bit_sel(mem_bit_sel),
        .mem_bit_val(mem_bit_val),
        .mem_rd(mem_rd),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .match_irq(match_irq),
        .overflow_irq(overflow_irq),
        .combined_irq(combined_irq)
    );

    // 50 MHz clock and cycle count
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // word write: strobe held for one sampling edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1 mem_addr = a;
        mem_wdata = d;
        mem_we = 1'b1;
        @(posedge clk_sys);
        #1 mem_we = 1'b0;
    endtask

    // single-bit write of the control register
    task automatic bw(input logic [2:0] b, input logic val);
        @(posedge clk_sys);
        #1 mem_addr = tmr_pkg::CTL_ADDR;
        mem_bit_sel = b;
        mem_bit_val = val;
        mem_bit_we = 1'b1;
        @(posedge clk_sys);
        #1 mem_bit_we = 1'b0;
    endtask

    // read: data stands from the cycle after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        #1 mem_addr = a;
        mem_rd = 1'b1;
        @(posedge clk_sys);
        #1 mem_rd = 1'b0;
        d = mem_rdata;
    endtask

    // bounded wait until a pulse queue holds n entries
    task automatic wait_q(input int which, input int n, input int lim);
        int k;
        k = 0;
        while (((which == 0) ? mq.size() : oq.size()) < n && k < lim) begin
            @(posedge clk_sys);
            k++;
        end
        check(16'(k < lim), 16'h0001);
    endtask

    // records pulse cycles and compares the combined request
    always @(negedge clk_sys) begin
        if (srst === 1'b0) begin
            if (match_irq === 1'b1) mq.push_back(cyc);
            if (overflow_irq === 1'b1) oq.push_back(cyc);
            check({15'h0, combined_irq},
                  {15'h0, match_irq | overflow_irq});
        end
    end

    // watchdog sized above the longest expected run
    initial begin
        repeat (98000) @(posedge clk_sys);
        failures++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int sel;
        int cmp;
        int r;
        seed = 8637;
        cyc = 0;
        failures = 0;
        checks = 0;
        srst = 1'b1;
        mem_addr = 16'h0000;
        mem_we = 1'b0;
        mem_bit_we = 1'b0;
        mem_bit_sel = 3'h0;
        mem_bit_val = 1'b0;
        mem_rd = 1'b0;
        mem_wdata = 16'h0000;
        repeat (20) @(posedge clk_sys);
        #1 srst = 1'b0;
        // reset values and an unmapped address
        rd(tmr_pkg::CTL_ADDR, v);
        check(v, 16'h0000);
        rd(tmr_pkg::CMP_ADDR, v);
        check(v, 16'h0000);
        rd(16'hff5d, v);
        check(v, 16'h0000);
        $display("reset values done");
        // clear-and-start mode over all four count clock ratios
        for (int i = 0; i < 4; i++) begin
            sel = i;
            r = (i == 0) ? 1 : (i == 1) ? 4 : (i == 2) ? 32 : 1024;
            cmp = (i == 0) ? (($random(seed) & 63) + 1) : (i == 1) ? 0 :
                  (i == 2) ? ($random(seed) & 7) : 2;
            wr(tmr_pkg::CMP_ADDR, 16'(cmp));
            // started from stop, reserved bits zero, clear mode
            wr(tmr_pkg::CTL_ADDR, 16'h0080 | 16'(sel));
            mq.delete();
            oq.delete();
            wait_q(0, 4, 5 * (cmp + 1) * r + 40);
            for (int j = 1; j < 4 && j < mq.size(); j++) begin
                check(16'(mq[j] - mq[j-1]), 16'((cmp + 1) * r));
            end
            check(16'(oq.size()), 16'h0000);
            wr(tmr_pkg::CTL_ADDR, 16'h0000);
            repeat (2) @(posedge clk_sys);
            mq.delete();
            repeat (2 * (cmp + 1) * r + 8) @(posedge clk_sys);
            check(16'(mq.size()), 16'h0000);
            $display("clear mode sel %0d compare %0d done", sel, cmp);
        end
        // free-running mode: match, all-ones compare, wrap
        wr(tmr_pkg::CMP_ADDR, 16'h0010);
        mq.delete();
        oq.delete();
        wr(tmr_pkg::CTL_ADDR, 16'h00c0);
        wait_q(0, 1, 64);
        // live rewrite lands well away from the running count
        wr(tmr_pkg::CMP_ADDR, 16'hffff);
        wait_q(1, 1, 70000);
        if (mq.size() > 0 && oq.size() > 0) begin
            check(16'(oq[0] - mq[0]), 16'hffef);
        end
        check(16'(mq.size()), 16'h0001);
        rd(tmr_pkg::CTL_ADDR, v);
        check(v, 16'h00c8);
        bw(3'h3, 1'b0);
        rd(tmr_pkg::CTL_ADDR, v);
        check(v, 16'h00c8);
        wr(tmr_pkg::CMP_ADDR, 16'h0010);
        wait_q(0, 2, 64);
        if (mq.size() > 1 && oq.size() > 0) begin
            check(16'(mq[1] - oq[0]), 16'h0011);
        end
        bw(3'h7, 1'b0);
        repeat (2) @(posedge clk_sys);
        rd(tmr_pkg::CTL_ADDR, v);
        check(v, 16'h0040);
        wr(tmr_pkg::CTL_ADDR, 16'h0008);
        rd(tmr_pkg::CTL_ADDR, v);
        check(v, 16'h0000);
        $display("free running mode done");
        report_and_stop();
    end
endmodule
`default_nettype wire
